/* verilog/io_expander_port_interrupt_logic.v */
// port registers, pin paths and interrupt outputs of a 16-bit expander
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_defines.vh"

module io_expander_port_interrupt_logic
(
  // clock and reset
  input  wire                 clk_i,
  input  wire                 srst_i,
  // register access from the serial protocol engine
  input  wire [`ADDR_W-1:0]   reg_addr_i,
  input  wire                 reg_wr_i,
  input  wire [`DATA_W-1:0]   reg_wdata_i,
  input  wire                 reg_rd_i,
  input  wire                 rd_lsb_done_i,
  output reg  [`DATA_W-1:0]   reg_rdata_o,
  output reg                  reg_rvalid_o,
  // port pins, second port in the upper byte
  input  wire [`PINS_W-1:0]   pins_i,
  output reg  [`PINS_W-1:0]   pins_o,
  output reg  [`PINS_W-1:0]   pins_oe_o,
  output reg  [`PINS_W-1:0]   pullup_o,
  // interrupt pads
  output reg                  irq_out_first_o,
  output reg                  irq_out_first_oe_o,
  output reg                  irq_out_second_o,
  output reg                  irq_out_second_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [`DATA_W-1:0] get_byte;
    input [`PINS_W-1:0] v;
    input               sel;
    begin
      get_byte = sel ? v[`PINS_W-1:`PORT_W] : v[`PORT_W-1:0];
    end
  endfunction

  function [`PINS_W-1:0] put_byte;
    input [`PINS_W-1:0] v;
    input               sel;
    input [`DATA_W-1:0] d;
    begin
      put_byte = sel ? {d, v[`PORT_W-1:0]} : {v[`PINS_W-1:`PORT_W], d};
    end
  endfunction

  // pad value and enable from the internal active-high request
  function [1:0] pad_drive;
    input active;
    input open_drain;
    input pol_high;
    begin
      if (open_drain)
        pad_drive = {1'b0, active};
      else
        pad_drive = {~(active ^ pol_high), 1'b1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [`PINS_W-1:0]  pin_meta_r;
  reg  [`PINS_W-1:0]  pin_sync_r;

  reg  [`PINS_W-1:0]  dir_r;
  reg  [`PINS_W-1:0]  en_r;
  reg  [`PINS_W-1:0]  def_r;
  reg  [`PINS_W-1:0]  src_r;
  reg  [`PINS_W-1:0]  pu_r;
  reg  [`PINS_W-1:0]  lat_r;
  reg  [`DATA_W-1:0]  cfg_r;

  reg  [1:0]          clr_arm_r;
  wire [1:0]          clr_port;

  wire [`IDX_W-1:0]   idx;
  wire                psel;
  wire                rd_clears;

  wire [`PORT_W-1:0]  flags_a;
  wire [`PORT_W-1:0]  flags_b;
  wire [`PORT_W-1:0]  cap_a;
  wire [`PORT_W-1:0]  cap_b;
  wire                irq_a;
  wire                irq_b;
  wire                req_first;
  wire                req_second;
  wire [1:0]          drv_first;
  wire [1:0]          drv_second;

  reg  [`DATA_W-1:0]  rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  // pins are asynchronous to clk_i, so two flops before any use
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_meta_r <= `RST_ZERO16;
      pin_sync_r <= `RST_ZERO16;
    end
    else
    begin
      pin_meta_r <= pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  assign idx       = reg_addr_i[`ADDR_IDX_HI:`ADDR_IDX_LO];
  assign psel      = reg_addr_i[`ADDR_PORT_BIT];
  assign rd_clears = (idx == `IDX_PORT) | (idx == `IDX_CAP);

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      dir_r <= `RST_DIR;
      en_r  <= `RST_ZERO16;
      def_r <= `RST_ZERO16;
      src_r <= `RST_ZERO16;
      pu_r  <= `RST_ZERO16;
      lat_r <= `RST_ZERO16;
      cfg_r <= `RST_CFG;
    end
    else if (reg_wr_i)
    begin
      case (idx)
        `IDX_DIR:
          dir_r <= put_byte(dir_r, psel, reg_wdata_i);
        `IDX_EN:
          en_r  <= put_byte(en_r, psel, reg_wdata_i);
        `IDX_DEF:
          def_r <= put_byte(def_r, psel, reg_wdata_i);
        `IDX_SRC:
          src_r <= put_byte(src_r, psel, reg_wdata_i);
        `IDX_CFG:
          cfg_r <= reg_wdata_i & `CFG_WMASK;
        `IDX_PU:
          pu_r  <= put_byte(pu_r, psel, reg_wdata_i);
        `IDX_PORT:
          lat_r <= put_byte(lat_r, psel, reg_wdata_i);
        `IDX_LAT:
          lat_r <= put_byte(lat_r, psel, reg_wdata_i);
        default:
          // flag and capture writes fall here and are dropped
          lat_r <= lat_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  always @*
  begin
    rdata_nxt = `RST_ZERO8;
    case (idx)
      `IDX_DIR:
        rdata_nxt = get_byte(dir_r, psel);
      `IDX_EN:
        rdata_nxt = get_byte(en_r, psel);
      `IDX_DEF:
        rdata_nxt = get_byte(def_r, psel);
      `IDX_SRC:
        rdata_nxt = get_byte(src_r, psel);
      `IDX_CFG:
        rdata_nxt = cfg_r;
      `IDX_PU:
        rdata_nxt = get_byte(pu_r, psel);
      `IDX_FLAG:
        rdata_nxt = psel ? flags_b : flags_a;
      `IDX_CAP:
        rdata_nxt = psel ? cap_b : cap_a;
      `IDX_PORT:
        rdata_nxt = get_byte(pin_sync_r, psel);
      `IDX_LAT:
        rdata_nxt = get_byte(lat_r, psel);
      default:
        rdata_nxt = `RST_ZERO8;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o  <= `RST_ZERO8;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-clear tracking

  // the clear waits for the lsb, so a read aborted early leaves it pending
  always @(posedge clk_i)
  begin
    if (srst_i)
      clr_arm_r <= 2'b00;
    else if (reg_rd_i)
      clr_arm_r <= rd_clears ? {psel, ~psel} : 2'b00;
    else if (rd_lsb_done_i)
      clr_arm_r <= 2'b00;
  end

  assign clr_port = {2{rd_lsb_done_i}} & clr_arm_r;

  ////////////////////////////////////////////////////////////////////////////
  // per-port interrupt units

  ioc_port_unit u_port_first
  (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .pins_i    (pin_sync_r[`PORT_W-1:0]),
    .dir_in_i  (dir_r[`PORT_W-1:0]),
    .irq_en_i  (en_r[`PORT_W-1:0]),
    .src_def_i (src_r[`PORT_W-1:0]),
    .def_val_i (def_r[`PORT_W-1:0]),
    .clr_i     (clr_port[0]),
    .flags_o   (flags_a),
    .cap_o     (cap_a),
    .irq_o     (irq_a)
  );

  ioc_port_unit u_port_second
  (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .pins_i    (pin_sync_r[`PINS_W-1:`PORT_W]),
    .dir_in_i  (dir_r[`PINS_W-1:`PORT_W]),
    .irq_en_i  (en_r[`PINS_W-1:`PORT_W]),
    .src_def_i (src_r[`PINS_W-1:`PORT_W]),
    .def_val_i (def_r[`PINS_W-1:`PORT_W]),
    .clr_i     (clr_port[1]),
    .flags_o   (flags_b),
    .cap_o     (cap_b),
    .irq_o     (irq_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing and pads

  // mirrored pads stay active while either port has an interrupt pending
  assign req_first  = cfg_r[`CFG_MIRROR] ? (irq_a | irq_b) : irq_a;
  assign req_second = cfg_r[`CFG_MIRROR] ? (irq_a | irq_b) : irq_b;

  assign drv_first  = pad_drive(req_first, cfg_r[`CFG_OPEN], cfg_r[`CFG_POL]);
  assign drv_second = pad_drive(req_second, cfg_r[`CFG_OPEN], cfg_r[`CFG_POL]);

  // reset value is push-pull active-low, idle level high
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      irq_out_first_o     <= 1'b1;
      irq_out_first_oe_o  <= 1'b1;
      irq_out_second_o    <= 1'b1;
      irq_out_second_oe_o <= 1'b1;
    end
    else
    begin
      irq_out_first_o     <= drv_first[1];
      irq_out_first_oe_o  <= drv_first[0];
      irq_out_second_o    <= drv_second[1];
      irq_out_second_oe_o <= drv_second[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers and pull-ups

  // direction bit 1 means input; pull-ups never fight an output
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pins_o    <= `RST_ZERO16;
      pins_oe_o <= `RST_ZERO16;
      pullup_o  <= `RST_ZERO16;
    end
    else
    begin
      pins_o    <= lat_r;
      pins_oe_o <= ~dir_r;
      pullup_o  <= pu_r & dir_r;
    end
  end

endmodule // io_expander_port_interrupt_logic

`default_nettype wire

/* verilog/ioexp_defines.vh */
// constants shared by the expander port and interrupt logic
`ifndef IOEXP_DEFINES_VH
`define IOEXP_DEFINES_VH

// register bus widths
`define ADDR_W        5
`define IDX_W         4
`define DATA_W        8
`define PORT_W        8
`define PINS_W        16

// register index, byte address = {index, port select}
`define IDX_DIR       4'h0
`define IDX_EN        4'h2
`define IDX_DEF       4'h3
`define IDX_SRC       4'h4
`define IDX_CFG       4'h5
`define IDX_PU        4'h6
`define IDX_FLAG      4'h7
`define IDX_CAP       4'h8
`define IDX_PORT      4'h9
`define IDX_LAT       4'hA

// address fields
`define ADDR_PORT_BIT 0
`define ADDR_IDX_HI   4
`define ADDR_IDX_LO   1

// expander_config fields
`define CFG_MIRROR    6
`define CFG_OPEN      2
`define CFG_POL       1
`define CFG_WMASK     8'hFE

// reset values
`define RST_DIR       16'hFFFF
`define RST_ZERO16    16'h0000
`define RST_ZERO8     8'h00
`define RST_CFG       8'h00

`endif

/* verilog/ioc_port_unit.v */
// change detection, capture, flags and clear for one 8-bit port
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_defines.vh"

module ioc_port_unit
(
  // clock and reset
  input  wire                 clk_i,
  input  wire                 srst_i,
  // synchronised pin levels and per-pin setup
  input  wire [`PORT_W-1:0]   pins_i,
  input  wire [`PORT_W-1:0]   dir_in_i,
  input  wire [`PORT_W-1:0]   irq_en_i,
  input  wire [`PORT_W-1:0]   src_def_i,
  input  wire [`PORT_W-1:0]   def_val_i,
  // clear request after lsb of a port or capture read
  input  wire                 clr_i,
  // state
  output reg  [`PORT_W-1:0]   flags_o,
  output reg  [`PORT_W-1:0]   cap_o,
  output reg                  irq_o
);

  reg  [`PORT_W-1:0] ref_r;
  wire [`PORT_W-1:0] ref_eff;
  wire [`PORT_W-1:0] qual;
  wire [`PORT_W-1:0] cond;
  wire               fire;

  ////////////////////////////////////////////////////////////////////////////
  // detection

  // on a clear the reference becomes the captured level
  assign ref_eff = clr_i ? cap_o : ref_r;
  assign qual    = irq_en_i & dir_in_i;
  assign cond    = qual & ((src_def_i & (pins_i ^ def_val_i))
                        | (~src_def_i & (pins_i ^ ref_eff)));
  // pending interrupt blocks new ones; a clear re-arms in the same cycle
  assign fire    = (|cond) & (~irq_o | clr_i);

  ////////////////////////////////////////////////////////////////////////////
  // state

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flags_o <= `RST_ZERO8;
      cap_o   <= `RST_ZERO8;
      irq_o   <= 1'b0;
      ref_r   <= `RST_ZERO8;
    end
    else
    begin
      if (fire)
      begin
        irq_o   <= 1'b1;
        cap_o   <= pins_i;
        flags_o <= cond;
      end
      else if (clr_i)
      begin
        irq_o   <= 1'b0;
        flags_o <= `RST_ZERO8;
      end
      if (clr_i)
        ref_r <= cap_o;
      else if (~irq_o & ~(|cond))
        ref_r <= pins_i;
    end
  end

endmodule // ioc_port_unit

`default_nettype wire

/* testbench/ioexp_checker_assertions.sv */
// port-level checks for the expander register and interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_defines.vh"
module ioexp_checker
(
  // clock and reset
  input wire logic               clk_i,
  input wire logic               srst_i,
  // register access
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic               reg_wr_i,
  input wire logic [`DATA_W-1:0] reg_wdata_i,
  input wire logic               reg_rd_i,
  input wire logic               rd_lsb_done_i,
  input wire logic [`DATA_W-1:0] reg_rdata_o,
  input wire logic               reg_rvalid_o,
  // pins and pads
  input wire logic [`PINS_W-1:0] pins_i,
  input wire logic [`PINS_W-1:0] pins_o,
  input wire logic [`PINS_W-1:0] pins_oe_o,
  input wire logic [`PINS_W-1:0] pullup_o,
  input wire logic               irq_out_first_o,
  input wire logic               irq_out_first_oe_o,
  input wire logic               irq_out_second_o,
  input wire logic               irq_out_second_oe_o
);
  logic [`PINS_W-1:0] pins_d_r;
  logic [3:0]         quiet_r;
  // cycles since anything that may legally move a pad
  always @(posedge clk_i)
  begin
    pins_d_r <= pins_i;
    if (srst_i || reg_wr_i || rd_lsb_done_i || pins_i != pins_d_r)
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hF)
      quiet_r <= quiet_r + 4'h1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  chk_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe got no valid");
  chk_valid_only: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("valid without read strobe");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_pullup_input: assert property ((pullup_o & pins_oe_o) == 16'h0000)
    else $error("pull-up on a driven pin");
  chk_od_first: assert property (!irq_out_first_oe_o |-> !irq_out_first_o)
    else $error("first pad released but high");
  chk_od_second: assert property (!irq_out_second_oe_o |-> !irq_out_second_o)
    else $error("second pad released but high");
  chk_latch_write: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> $stable(pins_o))
    else $error("pin outputs moved without a write");
  chk_dir_write: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> $stable({pins_oe_o, pullup_o}))
    else $error("enables moved without a write");
  chk_irq_quiet: assert property (quiet_r >= 4'h8 |-> $stable({irq_out_first_o,
    irq_out_first_oe_o, irq_out_second_o, irq_out_second_oe_o}))
    else $error("pad moved with no cause");
endmodule // ioexp_checker
bind io_expander_port_interrupt_logic ioexp_checker i_ioexp_checker
(
  .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .rd_lsb_done_i(rd_lsb_done_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pins_i(pins_i),
  .pins_o(pins_o), .pins_oe_o(pins_oe_o), .pullup_o(pullup_o),
  .irq_out_first_o(irq_out_first_o), .irq_out_first_oe_o(irq_out_first_oe_o),
  .irq_out_second_o(irq_out_second_o), .irq_out_second_oe_o(irq_out_second_oe_o)
);
`default_nettype wire

/* testbench/pin_world.sv */
// pin-side world: resolves each pin from device, pull-up and outside driver
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_defines.vh"
module pin_world
(
  // clock
  input  wire logic               clk_i,
  // device side
  input  wire logic [`PINS_W-1:0] drv_i,
  input  wire logic [`PINS_W-1:0] oe_i,
  input  wire logic [`PINS_W-1:0] pu_i,
  // outside drivers
  input  wire logic [`PINS_W-1:0] ext_val_i,
  input  wire logic [`PINS_W-1:0] ext_en_i,
  // resolved levels
  output logic [`PINS_W-1:0]      level_o
);
  logic flt_r = 1'b0;
  // a floating line wanders, so it never passes for a steady level
  always @(posedge clk_i)
    flt_r <= ~flt_r;
  always @*
    for (int i = 0; i < `PINS_W; i++)
      level_o[i] = oe_i[i] ? drv_i[i] : ext_en_i[i] ? ext_val_i[i] : pu_i[i] | flt_r;
endmodule // pin_world
`default_nettype wire

/* testbench/testbench.sv */
// testbench for the expander port registers and interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_defines.vh"
module testbench;
  logic               clk_i = 1'b0;
  logic               srst_i = 1'b1;
  logic [`ADDR_W-1:0] reg_addr_i = 5'h00;
  logic               reg_wr_i = 1'b0;
  logic [`DATA_W-1:0] reg_wdata_i = 8'h00;
  logic               reg_rd_i = 1'b0;
  logic               rd_lsb_done_i = 1'b0;
  logic [`DATA_W-1:0] reg_rdata_o;
  logic               reg_rvalid_o;
  logic [`PINS_W-1:0] lvl, pins_o, pins_oe_o, pullup_o;
  logic [`PINS_W-1:0] ext_val = 16'h0000;
  logic [`PINS_W-1:0] ext_en = 16'hFFFF;
  logic               fo, foe, so, soe;
  logic [7:0]         cfg_t [4] = '{8'h00, 8'h02, 8'h04, 8'h06};
  logic [3:0]         idle_t [4] = '{4'hF, 4'h5, 4'h0, 4'h0};
  int                 n_fail = 0;
  int                 total_checks = 0;
  always #5 clk_i = ~clk_i;
  io_expander_port_interrupt_logic i_io_expander_port_interrupt_logic
  (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .rd_lsb_done_i(rd_lsb_done_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pins_i(lvl),
    .pins_o(pins_o), .pins_oe_o(pins_oe_o), .pullup_o(pullup_o),
    .irq_out_first_o(fo), .irq_out_first_oe_o(foe),
    .irq_out_second_o(so), .irq_out_second_oe_o(soe)
  );
  pin_world i_pin_world
  (
    .clk_i(clk_i), .drv_i(pins_o), .oe_i(pins_oe_o), .pu_i(pullup_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(lvl)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    int i;
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++)
      @(negedge clk_i);
    chk("rvalid", 16'h0001, {15'h0000, reg_rvalid_o});
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
    if (i == 4)
      close_out();
  endtask
  // lsb of the last read byte has left the shifter
  task automatic lsb();
    @(negedge clk_i);
    rd_lsb_done_i = 1'b1;
    @(negedge clk_i);
    rd_lsb_done_i = 1'b0;
  endtask
  task automatic pad(input logic [3:0] e);
    int i;
    for (i = 0; i < 12 && {fo, foe, so, soe} !== e; i++)
      @(negedge clk_i);
    chk("pads", {12'h000, e}, {12'h000, fo, foe, so, soe});
    if (i == 12)
      close_out();
  endtask
  task automatic stay(input logic [3:0] e);
    repeat (10) @(negedge clk_i);
    pad(e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    pad(4'hF);
    rd(5'h0E, 8'h00);
    rd(5'h14, 8'h00);
    wr(5'h0E, 8'hFF);
    rd(5'h0E, 8'h00);
    wr(5'h1E, 8'h5A);
    rd(5'h1E, 8'h00);
    wr(5'h00, 8'h0F);
    ext_en = 16'hFF0F;
    ext_val = 16'h0003;
    wr(5'h12, 8'hA5);
    rd(5'h14, 8'hA5);
    wr(5'h0C, 8'hFF);
    rd(5'h12, 8'hA3);
    chk("pins_o", 16'h00A5, pins_o);
    chk("pins_oe", 16'h00F0, pins_oe_o);
    chk("pullup", 16'h000F, pullup_o);
    wr(5'h04, 8'h11);
    wr(5'h14, 8'hB5);
    stay(4'hF);
    ext_val = 16'h0000;
    pad(4'h7);
    rd(5'h0E, 8'h01);
    wr(5'h10, 8'h00);
    wr(5'h12, 8'hB5);
    ext_val = 16'h0001;
    stay(4'h7);
    rd(5'h10, 8'hB0);
    lsb();
    stay(4'h7);
    rd(5'h10, 8'hB1);
    rd(5'h12, 8'hB1);
    pad(4'h7);
    lsb();
    pad(4'hF);
    rd(5'h0E, 8'h00);
    wr(5'h0A, 8'h40);
    wr(5'h09, 8'h01);
    wr(5'h05, 8'h01);
    ext_val = 16'h0101;
    pad(4'h5);
    rd(5'h12, 8'hB1);
    lsb();
    stay(4'h5);
    rd(5'h11, 8'h01);
    lsb();
    stay(4'h5);
    ext_val = 16'h0001;
    repeat (4) @(negedge clk_i);
    rd(5'h13, 8'h00);
    lsb();
    pad(4'hF);
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h0A, cfg_t[k]);
      pad(idle_t[k]);
    end
    ext_val = 16'h0101;
    pad(4'h1);
    close_out();
  end
endmodule // testbench
`default_nettype wire
